//--- core/pmic_sup_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef PMIC_SUP_MAP_VH
`define PMIC_SUP_MAP_VH
`define OFS_EVENT 12'h000
`define OFS_MASK 12'h004
`define OFS_CTRL 12'h008
`define OFS_MEAS 12'h00C
`define OFS_UVLO 12'h010
`define OFS_PARK 12'h014
`define OFS_STATE 12'h018
`define EV_HOT 0
`define EV_TSD 1
`define EV_BATLOW 2
`define EV_UVLO 3
`define EV_MIRFLT 4
`define EV_V6PGF 5
`define EV_LEDOVP 6
`define EV_LSPGF 7
`define EV_WIDTH 8
`define CTRL_MIR_EN 0
`define CTRL_LED_EN 1
`define MEAS_SEL_LSB 0
`define MEAS_GAIN_LSB 4
`define MEAS_CAL_BIT 6
`define MASK_RESET 8'h00
`define UVLO_RESET 5'h00
`define UVLO_MAX 5'h1F
`define PARK_RESET 7'h64
`define PARK_MAX_US 7'h64
`define CLK_MHZ 16'h000A
`define CYC_PER_US 4'hA
`define V6_RETRY_US 16'h0032
`define V6_RETRY_CYC (`V6_RETRY_US * `CLK_MHZ)
`define DISCH_CYC 16'h0010
`define SEL_NONE 4'h8
`define SEL_MAX 4'h9
`endif

//--- core/sync2.v
// two-flop synchroniser, one per bit of a bus
`timescale 1ns/1ns
module sync2 #(
   parameter W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire [W-1:0] din,
   output wire [W-1:0] dout
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg s1_q;
         reg s2_q;
         // first stage feeds only the second stage
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
            end
            else if (ce)
            begin
               s1_q <= din[i];
               s2_q <= s1_q;
            end
         end
         assign dout[i] = s2_q;
      end
   endgenerate
endmodule

//--- core/pmic_fault_supervisor.v
// fault supervisor of the power-management block, apb register slave
//
// Contract
// - mux select field routes one of ten inputs, code 8 none, 9 reference
// - over-warning temperature raises hot event, rails untouched
// - thermal shutdown disables all rails and sets trip flag
// - after cooling, mirror rails stay off until enable rewritten
// - low battery raises event only, outputs keep working
// - lockout raises event, sequences rails down, clears enable, standby
// - lockout threshold programmable in 31 steps, 2.3 V to 4.5 V
// - after lockout, rails stay off until input good and pin toggled
// - lockout waits parking time 0..100 us, then fast discharge
// - mirror regulator fault sets flag, clears enable, stops regulator
// - clearing mirror enable also powers down the led driver
// - six volt power-good loss sets flag, stops led converter, retries
// - led supply overvoltage sets event, converter keeps running
// - below about 100 mA the led converter skips pulses
// - load switch under 1.3 V fast-discharges mirror rails at once
// - after load switch failure stay down until power pin cycled
// - events set sticky bits and pull interrupt low; read clears
// - masks gate only the interrupt, not bits or protection; here the mirror fault mask also keeps its fault from setting the lockout latch
// - power pin low: rails off, registers reset, bus ignored, reset low
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "pmic_sup_map.vh"
module pmic_fault_supervisor #(
   parameter V6_RETRY_CYCLES = `V6_RETRY_CYC
) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire power_on_pin,
   input wire hot_warn_cmp,
   input wire thermal_trip_cmp,
   input wire battery_weak_cmp,
   input wire uvlo_cmp,
   input wire input_above_recover_cmp,
   input wire mirror_rail_fault_cmp,
   input wire mirror_ind_fault_cmp,
   input wire six_volt_pg_cmp,
   input wire led_overvolt_cmp,
   input wire load_switch_low_cmp,
   input wire led_low_current_cmp,
   output reg [3:0] meas_input_select,
   output reg [1:0] meas_gain_code,
   output reg meas_calib_disable,
   output reg [4:0] uvlo_threshold_code,
   output reg mirror_regulator_on,
   output reg mirror_fast_discharge,
   output reg led_converter_on,
   output reg led_power_save,
   output reg core_power_on,
   output reg reset_out_n,
   output wire irq_out_n_o,
   output wire irq_out_n_oe
);
   localparam ST_OFF = 2'h0;
   localparam ST_STANDBY = 2'h1;
   localparam ST_PARK = 2'h2;
   localparam ST_DISCH = 2'h3;

   wire [10:0] mon_s;
   wire pwr_s;
   reg pwr_d1_q;
   reg [1:0] state_q;
   reg [7:0] event_q;
   reg [7:0] mask_q;
   reg mir_en_q;
   reg led_en_q;
   reg [6:0] park_us_q;
   reg [15:0] cnt_q;
   reg [3:0] us_div_q;
   reg lock_q;
   reg v6_wait_q;
   reg [15:0] v6_cnt_q;

   // sync inputs: every comparator and the power pin pass two flops
   sync2 #(.W(12)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(clk_en),
      .din({power_on_pin, led_low_current_cmp, load_switch_low_cmp,
            led_overvolt_cmp, six_volt_pg_cmp, mirror_ind_fault_cmp,
            mirror_rail_fault_cmp, input_above_recover_cmp, uvlo_cmp,
            battery_weak_cmp, thermal_trip_cmp, hot_warn_cmp}),
      .dout({pwr_s, mon_s})
   );

   wire hot_s = mon_s[0];
   wire tsd_s = mon_s[1];
   wire bat_s = mon_s[2];
   wire uvlo_s = mon_s[3];
   wire vin_ok_s = mon_s[4];
   wire mir_flt_s = mon_s[5] | mon_s[6];
   wire v6_bad_s = ~mon_s[7];
   wire ovp_s = mon_s[8];
   wire ls_low_s = mon_s[9];
   wire led_lowi_s = mon_s[10];

   // apb: zero wait states, error on unmapped offsets
   wire acc = psel & penable & clk_en;
   wire wr = acc & pwrite & pwr_s;
   wire rd = acc & ~pwrite & pwr_s;
   wire mapped = (paddr == `OFS_EVENT) | (paddr == `OFS_MASK) |
      (paddr == `OFS_CTRL) | (paddr == `OFS_MEAS) |
      (paddr == `OFS_UVLO) | (paddr == `OFS_PARK) | (paddr == `OFS_STATE);
   assign pready = 1'b1;
   // bus ignored: while the pin is low every access is refused
   assign pslverr = psel & penable & (~mapped | ~pwr_s);

   wire pwr_rise = pwr_s & ~pwr_d1_q;
   wire mir_flt_ev = mir_flt_s & mir_en_q;
   wire lockout_ev = uvlo_s & (state_q != ST_PARK) & (state_q != ST_DISCH);
   // any fault that forces the mirror enable low this cycle
   wire kill_mir = tsd_s | lockout_ev | ls_low_s | mir_flt_ev;

   // events raised by hardware this cycle
   wire [7:0] ev_set;
   assign ev_set[`EV_HOT] = hot_s;
   assign ev_set[`EV_TSD] = tsd_s;
   assign ev_set[`EV_BATLOW] = bat_s;
   assign ev_set[`EV_UVLO] = uvlo_s;
   assign ev_set[`EV_MIRFLT] = mir_flt_ev;
   assign ev_set[`EV_V6PGF] = v6_bad_s;
   assign ev_set[`EV_LEDOVP] = ovp_s;
   assign ev_set[`EV_LSPGF] = ls_low_s;

   // interrupt: open drain, oe low means the pin is pulled low
   // mask gate: masks touch the pin and the mirror-fault lockout latch, never bits
   wire irq_active = |(event_q & ~mask_q);
   assign irq_out_n_o = 1'b0;
   assign irq_out_n_oe = ~irq_active;

   // edge memory of the synchronised power pin
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pwr_d1_q <= 1'b0;
      else if (clk_en)
         pwr_d1_q <= pwr_s;
   end

   // register file and fault state; pin low acts as a synchronous reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         event_q <= 8'h00;
         mask_q <= `MASK_RESET;
         mir_en_q <= 1'b0;
         led_en_q <= 1'b0;
         meas_input_select <= `SEL_NONE;
         meas_gain_code <= 2'h1;
         meas_calib_disable <= 1'b0;
         uvlo_threshold_code <= `UVLO_RESET;
         park_us_q <= `PARK_RESET;
         lock_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!pwr_s)
         begin
            // registers default: everything back to reset values
            event_q <= 8'h00;
            mask_q <= `MASK_RESET;
            // enable zero: mirror enable starts cleared after the pin
            mir_en_q <= 1'b0;
            led_en_q <= 1'b0;
            meas_input_select <= `SEL_NONE;
            meas_gain_code <= 2'h1;
            meas_calib_disable <= 1'b0;
            uvlo_threshold_code <= `UVLO_RESET;
            park_us_q <= `PARK_RESET;
            // lockout release: pin seen low clears the latch
            lock_q <= 1'b0;
         end
         else
         begin
            // sticky events: a set in the read cycle survives the clear
            if (rd && paddr == `OFS_EVENT)
               event_q <= ev_set;
            else
               event_q <= event_q | ev_set;
            if (wr && paddr == `OFS_MASK)
               mask_q <= pwdata[7:0];
            if (wr && paddr == `OFS_MEAS)
            begin
               // input select: codes above nine fall back to none
               if (pwdata[`MEAS_SEL_LSB+3:`MEAS_SEL_LSB] > `SEL_MAX)
                  meas_input_select <= `SEL_NONE;
               else
                  meas_input_select <= pwdata[`MEAS_SEL_LSB+3:`MEAS_SEL_LSB];
               meas_gain_code <= pwdata[`MEAS_GAIN_LSB+1:`MEAS_GAIN_LSB];
               meas_calib_disable <= pwdata[`MEAS_CAL_BIT];
            end
            // threshold code: five bits, codes 0..31 above 2.3 V
            if (wr && paddr == `OFS_UVLO)
               uvlo_threshold_code <= pwdata[4:0];
            if (wr && paddr == `OFS_PARK)
            begin
               if (pwdata[6:0] > `PARK_MAX_US)
                  park_us_q <= `PARK_MAX_US;
               else
                  park_us_q <= pwdata[6:0];
            end
            // lockout latch: uvlo or load switch failure holds rails
            // stay down: only a pin cycle clears the latch
            // unmasked mirror fault also needs a pin cycle
            if (lockout_ev || ls_low_s ||
                (mir_flt_ev && !mask_q[`EV_MIRFLT]))
               lock_q <= 1'b1;
            if (wr && paddr == `OFS_CTRL)
               led_en_q <= pwdata[`CTRL_LED_EN];
            // fault first: a fault beats an enable write
            // trip: thermal shutdown clears the enable
            // mirror fault: enable cleared, regulator stops
            if (kill_mir)
               mir_en_q <= 1'b0;
            // rewrite: enable returns only by a host write
            // input low: enable refused below the recovery level
            else if (wr && paddr == `OFS_CTRL)
               mir_en_q <= pwdata[`CTRL_MIR_EN] & ~lock_q & vin_ok_s;
         end
      end
   end

   // lockout shutdown sequence: park, then discharge
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_OFF;
         cnt_q <= 16'h0000;
         us_div_q <= 4'h0;
      end
      else if (clk_en)
      begin
         case (state_q)
            ST_OFF:
               if (pwr_rise)
                  state_q <= ST_STANDBY;
            ST_STANDBY:
               if (!pwr_s)
                  state_q <= ST_OFF;
               // no parking: load switch loss discharges at once
               else if (ls_low_s)
               begin
                  state_q <= ST_DISCH;
                  cnt_q <= `DISCH_CYC;
               end
               // park first: wait the programmed microseconds
               else if (lockout_ev)
               begin
                  state_q <= ST_PARK;
                  cnt_q <= {9'h000, park_us_q};
                  us_div_q <= 4'h0;
               end
            ST_PARK:
               if (ls_low_s || cnt_q == 16'h0000)
               begin
                  state_q <= ST_DISCH;
                  cnt_q <= `DISCH_CYC;
               end
               else if (us_div_q == `CYC_PER_US - 4'h1)
               begin
                  us_div_q <= 4'h0;
                  cnt_q <= cnt_q - 16'h0001;
               end
               else
                  us_div_q <= us_div_q + 4'h1;
            ST_DISCH:
               if (cnt_q == 16'h0000)
                  state_q <= pwr_s ? ST_STANDBY : ST_OFF;
               else
                  cnt_q <= cnt_q - 16'h0001;
            default:
               state_q <= ST_OFF;
         endcase
      end
   end

   // retry: converter held off for a retry gap after power-good loss
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         v6_wait_q <= 1'b0;
         v6_cnt_q <= 16'h0000;
      end
      else if (clk_en)
      begin
         if (v6_bad_s)
         begin
            v6_wait_q <= 1'b1;
            v6_cnt_q <= V6_RETRY_CYCLES[15:0];
         end
         else if (v6_cnt_q != 16'h0000)
            v6_cnt_q <= v6_cnt_q - 16'h0001;
         else
            v6_wait_q <= 1'b0;
      end
   end

   // rail outputs, all registered
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mirror_regulator_on <= 1'b0;
         mirror_fast_discharge <= 1'b0;
         led_converter_on <= 1'b0;
         led_power_save <= 1'b0;
         core_power_on <= 1'b0;
         reset_out_n <= 1'b0;
      end
      else if (clk_en)
      begin
         // pin low: all rails off and reset held low
         // thermal trip drops the core rail too
         core_power_on <= pwr_s & ~lock_q & ~tsd_s &
            (state_q == ST_STANDBY);
         reset_out_n <= pwr_s & (state_q != ST_OFF);
         // warning only: hot and low battery do not gate rails
         mirror_regulator_on <= pwr_s & mir_en_q & ~kill_mir & ~lock_q &
            (state_q == ST_STANDBY);
         // fast discharge during the discharge phase
         mirror_fast_discharge <= (state_q == ST_DISCH);
         // overvoltage does not stop the converter
         led_converter_on <= pwr_s & mir_en_q & led_en_q & ~kill_mir &
            ~lock_q & ~v6_bad_s & ~v6_wait_q & (state_q == ST_STANDBY);
         // pulse skipping at low led current
         led_power_save <= led_lowi_s;
      end
   end

   // read data registered in the setup cycle, ready for the access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (clk_en && psel && !penable && !pwrite)
      begin
         case (paddr)
            `OFS_EVENT: prdata <= {24'h000000, event_q | ev_set};
            `OFS_MASK: prdata <= {24'h000000, mask_q};
            `OFS_CTRL: prdata <= {30'h00000000, led_en_q, mir_en_q};
            `OFS_MEAS: prdata <= {25'h0000000, meas_calib_disable,
               meas_gain_code, meas_input_select};
            `OFS_UVLO: prdata <= {27'h0000000, uvlo_threshold_code};
            `OFS_PARK: prdata <= {25'h0000000, park_us_q};
            `OFS_STATE: prdata <= {28'h0000000, lock_q, v6_wait_q, state_q};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule

//--- dv/sup_asserts.sv
// concurrent checks on the supervisor's output pins
`timescale 1ns/1ns
`include "pmic_sup_map.vh"
module sup_asserts (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire power_on_pin,
   input wire thermal_trip_cmp,
   input wire six_volt_pg_cmp,
   input wire load_switch_low_cmp,
   input wire led_low_current_cmp,
   input wire [3:0] meas_input_select,
   input wire mirror_regulator_on,
   input wire mirror_fast_discharge,
   input wire led_converter_on,
   input wire led_power_save,
   input wire core_power_on,
   input wire reset_out_n
);
   logic [7:0] dcnt_q;
   // length of the running discharge burst, saturating so it never wraps
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dcnt_q <= 8'h00;
      else if (!mirror_fast_discharge)
         dcnt_q <= 8'h00;
      else if (dcnt_q != 8'hFF)
         dcnt_q <= dcnt_q + 8'h01;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // pin low long enough to pass the synchroniser
   sequence s_pin_off;
      (!power_on_pin && clk_en) [*4];
   endsequence
   sequence s_held_low;
      !reset_out_n ##1 !reset_out_n;
   endsequence
   a_sel_range: assert property (meas_input_select <= `SEL_MAX)
      else $error("select code beyond the last input");
   a_trip_rails_off: assert property (
      (thermal_trip_cmp && clk_en) [*4] |=>
      !mirror_regulator_on && !led_converter_on && !core_power_on)
      else $error("rails still on in thermal shutdown");
   a_lsw_discharge: assert property (
      load_switch_low_cmp && mirror_regulator_on && power_on_pin && clk_en
      |-> ##[1:4] mirror_fast_discharge)
      else $error("no fast discharge on load switch loss");
   a_disch_length: assert property (
      $fell(mirror_fast_discharge) && power_on_pin |-> dcnt_q >= 8'h10)
      else $error("discharge burst too short");
   a_pin_low_off: assert property (s_pin_off |=> !reset_out_n &&
      !mirror_regulator_on && !led_converter_on && !core_power_on)
      else $error("outputs alive while power pin low");
   a_pin_sync: assert property ($rose(power_on_pin) |-> s_held_low)
      else $error("reset released before pin synchronised");
   a_led_follows: assert property (
      !mirror_regulator_on [*2] |-> !led_converter_on)
      else $error("led driver on without mirror rails");
   a_six_volt_off: assert property (
      (!six_volt_pg_cmp && clk_en) [*4] |=> !led_converter_on)
      else $error("led converter on without six volt rail");
   a_power_save: assert property (
      (led_low_current_cmp && led_converter_on && clk_en) [*4]
      |=> led_power_save)
      else $error("no pulse skipping at low current");
endmodule
bind pmic_fault_supervisor sup_asserts u_sup_asserts (.pclk, .presetn,
   .clk_en, .power_on_pin, .thermal_trip_cmp, .six_volt_pg_cmp,
   .load_switch_low_cmp, .led_low_current_cmp, .meas_input_select,
   .mirror_regulator_on, .mirror_fast_discharge, .led_converter_on,
   .led_power_save, .core_power_on, .reset_out_n);

//--- dv/apb_host.sv
// apb master standing in for the host display processor
`timescale 1ns/1ns
module apb_host (
   input wire pclk,
   input wire go,
   input wire wr,
   input wire [11:0] addr,
   input wire [31:0] wdata,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic done,
   output logic [31:0] rdata,
   output logic err
);
   initial {psel, penable, pwrite, paddr, pwdata, done, rdata, err} = '0;
   // one transfer per go; released lines invert so stale data never matches
   always @(posedge pclk)
   begin
      done <= 1'b0;
      if (go && !psel)
      begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= addr;
         pwdata <= wdata;
      end
      else if (psel && !penable)
         penable <= 1'b1;
      else if (penable && pready)
      begin
         psel <= 1'b0;
         penable <= 1'b0;
         done <= 1'b1;
         rdata <= prdata;
         err <= pslverr;
         paddr <= ~paddr;
         pwdata <= ~pwdata;
      end
   end
endmodule

//--- dv/tb.sv
// self-checking bench for the supervisor's protection logic
`timescale 1ns/1ns
`include "pmic_sup_map.vh"
module tb;
   logic pclk, presetn, clk_en, pin, go, hw, dn, er;
   logic [10:0] cm;
   logic [11:0] ha;
   logic [31:0] hd, rq;
   wire psel, penable, pwrite, pready, pslverr, irq_o, irq_oe, irq_n;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [3:0] meas_input_select;
   wire [4:0] uvlo_threshold_code;
   wire [1:0] meas_gain_code;
   wire meas_calib_disable, mirror_regulator_on, mirror_fast_discharge;
   wire led_converter_on, led_power_save, core_power_on, reset_out_n;
   int fail_count, checks;
   // pull-up on the open-drain interrupt line
   assign irq_n = irq_oe ? 1'b1 : irq_o;
   // short retry count keeps the run brief
   pmic_fault_supervisor #(.V6_RETRY_CYCLES(8)) u_pmic_fault_supervisor (
      .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .power_on_pin(pin),
      .hot_warn_cmp(cm[0]), .thermal_trip_cmp(cm[1]),
      .battery_weak_cmp(cm[2]), .uvlo_cmp(cm[3]),
      .input_above_recover_cmp(cm[4]), .mirror_rail_fault_cmp(cm[5]),
      .mirror_ind_fault_cmp(cm[6]), .six_volt_pg_cmp(cm[7]),
      .led_overvolt_cmp(cm[8]), .load_switch_low_cmp(cm[9]),
      .led_low_current_cmp(cm[10]), .meas_input_select, .meas_gain_code,
      .meas_calib_disable, .uvlo_threshold_code, .mirror_regulator_on,
      .mirror_fast_discharge, .led_converter_on, .led_power_save,
      .core_power_on, .reset_out_n, .irq_out_n_o(irq_o),
      .irq_out_n_oe(irq_oe));
   apb_host u_apb_host (.pclk, .go, .wr(hw), .addr(ha), .wdata(hd),
      .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
      .pwdata, .done(dn), .rdata(rq), .err(er));
   // free-running bus clock
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task results;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one host transfer, waiting on completion under a bound
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      go <= 1'b1;
      hw <= w;
      ha <= a;
      hd <= d;
      @(posedge pclk);
      go <= 1'b0;
      repeat (20)
      begin
         @(posedge pclk);
         if (dn)
            break;
      end
      if (dn !== 1'b1)
      begin
         fail_count++;
         results;
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rq, e);
   endtask
   task rails(input logic [1:0] e);
      chk({mirror_regulator_on, led_converter_on}, e);
   endtask
   task en;
      wr(`OFS_CTRL, 32'h3);
      step(4);
   endtask
   // power pin cycled off then on
   task tog;
      pin <= 1'b0;
      step(6);
      chk(reset_out_n, 1'b0);
      wr(`OFS_CTRL, 32'h3);
      chk(er, 1'b1);
      rails(2'b00);
      pin <= 1'b1;
      step(6);
      chk(reset_out_n, 1'b1);
      rd(`OFS_CTRL, 32'h0);
   endtask
   // comparator pulse: rails and line during it, sticky bit after it
   task pf(input int c, input int e, input logic [1:0] on, input logic m);
      cm[c] <= ~cm[c];
      step(6);
      rails(on);
      chk(irq_n, m);
      cm[c] <= ~cm[c];
      step(6);
      rd(`OFS_EVENT, 32'h1 << e);
      rd(`OFS_EVENT, 32'h0);
      chk(irq_n, 1'b1);
   endtask
   function logic [1:0] gain(input int c);
      return c == 4 ? 2'h3 : (c > 4 && c < 8) ? 2'h2 : 2'h1;
   endfunction
   // main sequence
   initial
   begin
      int c, p, n, mv;
      logic cal;
      {presetn, pin, go, hw, ha, hd, fail_count, checks} = '0;
      clk_en = 1'b1;
      cm = 11'h090;
      c = $urandom(32'h4CC3FFAC);
      step(2);
      presetn <= 1'b1;
      tog;
      rd(`OFS_MASK, 32'h0);
      rd(`OFS_PARK, 32'h64);
      rd(`OFS_MEAS, 32'h18);
      rd(12'h01C, 32'h0);
      chk(er, 1'b1);
      // host programs gain and calibration per input
      for (c = 0; c < 16; c++)
      begin
         mv = $urandom_range(300);
         cal = c == 4 ? mv > 100 : (c > 4 && c < 8) && mv > 200;
         wr(`OFS_MEAS, {25'h0, cal, gain(c), c[3:0]});
         chk(meas_input_select, c > 9 ? `SEL_NONE : c);
         chk(meas_gain_code, gain(c));
         chk(meas_calib_disable, cal);
      end
      for (c = 0; c < 2; c++)
      begin
         n = c ? 31 : $urandom_range(30);
         wr(`OFS_UVLO, n);
         chk(uvlo_threshold_code, n);
      end
      en;
      rails(2'b11);
      pf(0, `EV_HOT, 2'b11, 1'b0);
      wr(`OFS_MASK, 32'hFF);
      pf(2, `EV_BATLOW, 2'b11, 1'b1);
      pf(8, `EV_LEDOVP, 2'b11, 1'b1);
      wr(`OFS_MASK, 32'h0);
      cm[10] <= 1'b1;
      step(6);
      chk(led_power_save, 1'b1);
      cm[10] <= 1'b0;
      pf(7, `EV_V6PGF, 2'b10, 1'b0);
      rails(2'b11);
      pf(1, `EV_TSD, 2'b00, 1'b0);
      rails(2'b00);
      en;
      rails(2'b11);
      pf(5, `EV_MIRFLT, 2'b00, 1'b0);
      bus(1'b0, `OFS_CTRL, 32'h0);
      chk(rq[0], 1'b0);
      en;
      rails(2'b00);
      tog;
      en;
      wr(`OFS_MASK, 32'h10);
      pf(6, `EV_MIRFLT, 2'b00, 1'b1);
      en;
      rails(2'b11);
      pf(9, `EV_LSPGF, 2'b00, 1'b0);
      en;
      rails(2'b00);
      tog;
      en;
      p = $urandom_range(2, 1);
      wr(`OFS_PARK, p);
      cm[3] <= 1'b1;
      n = 0;
      while (mirror_fast_discharge !== 1'b1 && n < 60)
      begin
         step(1);
         n++;
      end
      chk(n >= p * 10 && n <= p * 10 + 8, 1'b1);
      cm[3] <= 1'b0;
      step(20);
      rd(`OFS_EVENT, 32'h8);
      bus(1'b0, `OFS_CTRL, 32'h0);
      chk(rq[0], 1'b0);
      en;
      rails(2'b00);
      cm[4] <= 1'b0;
      tog;
      en;
      rails(2'b00);
      cm[4] <= 1'b1;
      step(4);
      en;
      rails(2'b11);
      results;
   end
endmodule
